// [ptmr_defines.svh]
`ifndef PTMR_DEFINES_SVH
`define PTMR_DEFINES_SVH
// Register indices; byte address is four times the index
`define PTMR_IDX_FREE_FLAG  10'h001
`define PTMR_IDX_MULTI_FLAG 10'h002
`define PTMR_IDX_FREE_MODE  10'h008
`define PTMR_IDX_MODE_ONE   10'h009
`define PTMR_IDX_LOW        10'h00a
`define PTMR_IDX_HIGH       10'h00b
`define PTMR_IDX_CAP_FLAGS  10'h021
`define PTMR_IDX_PIN_FUNC   10'h024
`define PTMR_IDX_MODE_TWO   10'h026
// Field positions
`define PTMR_BIT_FREE_IRQ   2
`define PTMR_BIT_MULTI_IRQ  0
`define PTMR_BIT_CAP_STAT   0
`define PTMR_BIT_CAP_ERR    1
`define PTMR_BIT_PIN_EVENT  0
// Reset values
`define PTMR_RST_NIBBLE     4'h0
`define PTMR_RST_COUNT      8'h00
`define PTMR_RST_PRESCALE   11'h000
// Clock source code that picks the event pin
`define PTMR_SRC_EXT        3'h7
// Cycles from one mode-one write to the next that counts
`define PTMR_MODE_GAP_CYC   2
`endif

// [ptmr_pkg.sv]
package ptmr_pkg;
  // Event pin edge choice
  typedef enum logic [1:0] {
    PTMR_EDGE_NONE = 2'b00,
    PTMR_EDGE_FALL = 2'b01,
    PTMR_EDGE_RISE = 2'b10,
    PTMR_EDGE_BOTH = 2'b11
  } ptmr_edge_t;
  // First multifunction mode register
  typedef struct packed {
    logic       reload;
    logic [2:0] src;
  } ptmr_mode_one_t;
  // Second multifunction mode register
  typedef struct packed {
    logic       cap_en;
    ptmr_edge_t edge_sel;
  } ptmr_mode_two_t;
  // Capture flags pair
  typedef struct packed {
    logic err;
    logic stat;
  } ptmr_cap_t;
endpackage : ptmr_pkg

// [ptmr_top.sv]
// How it works
// - 11-bit prescaler cleared by reset, counts freely
// - Prescaler halts in reset and stop mode
// - Timer clocks come from selected prescaler taps, or the event pin in event mode
// - Free timer is 8-bit up-counter, reset clears
// - Free timer wraps at all-ones, sets flag
// - Four-bit write-only mode picks free timer clock
// - Multi timer overflow reloads or clears, continues
// - Overflow flag sticks until software or reset
// - Event mode counts falling, rising or both edges
// - Capture copies count, sets flags, clears timer
// - Trigger or overflow during status sets error
// - Capture flags clear on reset or zero write
// - Mode-one writes honoured two cycles apart only
// - Three-bit mode two picks edge and capture
// - Low write holds count, high write loads
// - Low load digit resets, high undefined
// - High read returns nibble, latches low outside capture mode
// - Captured value stays stable for reads
//
// Decided for this implementation: register access over APB.
`include "ptmr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ptmr_top
  import ptmr_pkg::*;
#(
  // Prescaler bit that ends each ratio code's period
  parameter logic [7:0][3:0] TAPS = {4'd10, 4'd9, 4'd8, 4'd7,
                                     4'd5, 4'd3, 4'd1, 4'd0}
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        stop_i,
  input  wire logic        event_input_pin_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             free_timer_irq_flag_o,
  output logic             multi_timer_irq_flag_o
);

  // Refuse taps beyond the prescaler's width
  for (genvar c = 0; c < 8; c++) begin : g_chk
    if (TAPS[c] > 4'd10) begin : g_bad
      $error("Prescaler tap out of range");
    end
  end

  // Prescaler and free timer state
  logic [10:0]    ps_q;          // Prescaler count
  logic [7:0]     tick;          // One tick per ratio code
  logic           ps_en;         // Prescaler advances
  logic [3:0]     ft_mode_q;     // Free timer mode
  logic [7:0]     ft_q;          // Free timer count
  logic           ft_tick;       // Free timer input clock
  logic           irq_free_q;    // Free timer flag
  // Multi timer, its mode and load registers
  ptmr_mode_one_t m1_q;          // Mode one
  ptmr_mode_two_t m2_q;          // Mode two
  logic [3:0]     pin_fn_q;      // Pin function
  logic [3:0]     ll_q;          // Load low digit
  logic [3:0]     lh_q;          // Load high digit
  logic [7:0]     mt_q;          // Multi timer count
  logic [7:0]     rd_q;          // Read register
  logic           irq_multi_q;   // Multi timer flag
  ptmr_cap_t      cap_q;         // Capture flags
  logic [1:0]     gap_q;         // Mode-one holdoff
  logic           pin_q;         // Previous pin level
  // Bus answer registers
  logic           rdy_q;         // Access answered
  logic           err_q;         // Unmapped access
  logic [31:0]    rdata_q;       // Read data
  // Combinational helpers
  logic [9:0]     idx;           // Register index
  logic           acc;           // Data capture edge
  logic           wr;            // Write completes
  logic           rd_hi;         // High digit read
  logic           ext_sel;       // Event counting
  logic           fall;          // Falling edge seen
  logic           rise;          // Rising edge seen
  logic           edge_hit;      // Chosen edge seen
  logic           trig;          // Capture trigger
  logic           mt_tick;       // Multi timer clock
  logic           mt_ovf;        // Multi timer overflow
  logic           m1_wr_ok;      // Mode-one write honoured
  logic           lh_wr;         // High load digit write
  logic           mapped;        // Index is decoded
  logic [31:0]    rmux;          // Read mux

  // Bus decode; the two low address bits are ignored
  // A low ce_i stalls a transfer before pready rises, but a write whose pready is already high is dropped
  assign idx   = paddr_i[11:2];
  assign ps_en = ce_i & ~stop_i;
  assign acc   = ce_i & psel_i & penable_i & ~rdy_q;
  assign wr    = ce_i & psel_i & penable_i & rdy_q & pwrite_i;
  assign rd_hi = acc & ~pwrite_i & (idx == `PTMR_IDX_HIGH);

  // Tap tick: low bits all ones so the tap bit is about to carry
  // Each tick lasts one cycle, so no timer counts twice per period
  for (genvar g = 0; g < 8; g++) begin : g_tap
    localparam logic [10:0] M = 11'((12'd2 << TAPS[g]) - 12'd1);
    assign tick[g] = ps_en & ((ps_q & M) == M);
  end

  // Prescaler, frozen by stop mode and reset
  // Freezing it also freezes every tap, hence both internal clocks
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ps_q <= `PTMR_RST_PRESCALE;
    end else if (ps_en) begin
      ps_q <= ps_q + 11'd1;
    end
  end

  // Free timer input clock from its mode code
  assign ft_tick = tick[ft_mode_q[2:0]];

  // Free timer count and overflow flag
  // Its clear is a write of zero to the flag bit; a one is ignored
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ft_q       <= `PTMR_RST_COUNT;
      irq_free_q <= 1'b0;
    end else if (ce_i) begin
      if (ft_tick) begin
        ft_q <= ft_q + 8'd1;
      end
      // Set wins over a clearing write in the same cycle
      if (ft_tick && ft_q == 8'hff) begin
        irq_free_q <= 1'b1;
      end else if (wr && idx == `PTMR_IDX_FREE_FLAG &&
                   !pwdata_i[`PTMR_BIT_FREE_IRQ]) begin
        irq_free_q <= 1'b0;
      end
    end
  end

  // Edge detector on the event pin, gated by its pin function
  // Pin function off keeps a floating pin from counting
  assign fall     = pin_q & ~event_input_pin_i;
  assign rise     = ~pin_q & event_input_pin_i;
  assign edge_hit = pin_fn_q[`PTMR_BIT_PIN_EVENT] &
                    ((m2_q.edge_sel[0] & fall) |
                     (m2_q.edge_sel[1] & rise));
  assign trig     = ce_i & m2_q.cap_en & edge_hit;

  // Capture mode always runs from the internal taps
  assign ext_sel = (m1_q.src == `PTMR_SRC_EXT) & ~m2_q.cap_en;
  assign mt_tick = ext_sel ? (ce_i & edge_hit)
                           : tick[m1_q.src];
  assign mt_ovf  = mt_tick & (mt_q == 8'hff);
  assign lh_wr   = wr & (idx == `PTMR_IDX_HIGH);

  // Previous pin level for edge detection
  // Resets low; the pin function bit masks the first false edge
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
    end else if (ce_i) begin
      pin_q <= event_input_pin_i;
    end
  end

  // Mode-one holdoff: a second write too soon is dropped
  assign m1_wr_ok = wr & (idx == `PTMR_IDX_MODE_ONE) &
                    (gap_q == 2'd0);

  // Holdoff counts down only while ce_i is high

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      gap_q <= 2'd0;
    end else if (ce_i) begin
      if (m1_wr_ok) begin
        gap_q <= 2'(`PTMR_MODE_GAP_CYC - 1);
      end else if (gap_q != 2'd0) begin
        gap_q <= gap_q - 2'd1;
      end
    end
  end

  // Write-only mode and pin registers
  // Mode one takes only writes that pass the holdoff
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ft_mode_q <= `PTMR_RST_NIBBLE;
      m1_q      <= `PTMR_RST_NIBBLE;
      m2_q      <= 3'h0;
      pin_fn_q  <= `PTMR_RST_NIBBLE;
      ll_q      <= `PTMR_RST_NIBBLE;
    end else if (wr) begin
      case (idx)
        `PTMR_IDX_FREE_MODE: ft_mode_q <= pwdata_i[3:0];
        `PTMR_IDX_MODE_TWO:  m2_q      <= pwdata_i[2:0];
        `PTMR_IDX_PIN_FUNC:  pin_fn_q  <= pwdata_i[3:0];
        `PTMR_IDX_LOW:       ll_q      <= pwdata_i[3:0];
        default: begin
          if (m1_wr_ok) begin
            m1_q <= pwdata_i[3:0];
          end
        end
      endcase
    end
  end

  // High load digit has no reset value
  // Reload before any high write would load an unknown value
  always_ff @(posedge clock_i) begin
    if (lh_wr) begin
      lh_q <= pwdata_i[3:0];
    end
  end

  // Multi timer: load beats capture, capture beats counting
  // Overflow in capture mode still follows the reload bit
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mt_q <= `PTMR_RST_COUNT;
    end else if (ce_i) begin
      // Software's load is the newest value, so it wins
      if (lh_wr) begin
        mt_q <= {pwdata_i[3:0], ll_q};
      end else if (trig) begin
        mt_q <= 8'h00;
      end else if (mt_ovf) begin
        mt_q <= m1_q.reload ? {lh_q, ll_q} : 8'h00;
      end else if (mt_tick) begin
        mt_q <= mt_q + 8'd1;
      end
    end
  end

  // Read register: capture snapshot or low-nibble latch
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_q <= `PTMR_RST_COUNT;
    end else if (ce_i) begin
      // Capture overwrites any pending low-digit latch
      if (trig) begin
        rd_q <= mt_q;
      end else if (rd_hi && !m2_q.cap_en) begin
        rd_q[3:0] <= mt_q[3:0];
      end
    end
  end

  // Sticky flags; hardware set wins over a clearing write
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      irq_multi_q <= 1'b0;
      cap_q       <= 2'b00;
    end else if (ce_i) begin
      if (mt_ovf || trig) begin
        irq_multi_q <= 1'b1;
      end else if (wr && idx == `PTMR_IDX_MULTI_FLAG &&
                   !pwdata_i[`PTMR_BIT_MULTI_IRQ]) begin
        irq_multi_q <= 1'b0;
      end
      // Status marks a capture that software has not yet cleared
      if (trig) begin
        cap_q.stat <= 1'b1;
      end else if (wr && idx == `PTMR_IDX_CAP_FLAGS &&
                   !pwdata_i[`PTMR_BIT_CAP_STAT]) begin
        cap_q.stat <= 1'b0;
      end
      // A second event before status is cleared is an error
      if (cap_q.stat && (trig || mt_ovf)) begin
        cap_q.err <= 1'b1;
      end else if (wr && idx == `PTMR_IDX_CAP_FLAGS &&
                   !pwdata_i[`PTMR_BIT_CAP_ERR]) begin
        cap_q.err <= 1'b0;
      end
    end
  end

  // Address decode; write-only registers read as zero
  // Unmapped indices answer with pslverr and change nothing
  always_comb begin
    rmux   = 32'h0000_0000;
    mapped = 1'b1;
    case (idx)
      `PTMR_IDX_FREE_FLAG:  rmux[`PTMR_BIT_FREE_IRQ]  = irq_free_q;
      `PTMR_IDX_MULTI_FLAG: rmux[`PTMR_BIT_MULTI_IRQ] = irq_multi_q;
      `PTMR_IDX_CAP_FLAGS:  rmux[1:0] = cap_q;
      `PTMR_IDX_LOW:        rmux[3:0] = rd_q[3:0];
      `PTMR_IDX_HIGH: begin
        // Capture keeps the snapshot so either order works
        rmux[3:0] = m2_q.cap_en ? rd_q[7:4] : mt_q[7:4];
      end
      `PTMR_IDX_FREE_MODE, `PTMR_IDX_MODE_ONE, `PTMR_IDX_PIN_FUNC,
      `PTMR_IDX_MODE_TWO:   rmux = 32'h0000_0000;
      default:              mapped = 1'b0;
    endcase
  end

  // APB answer one cycle into the access phase, all registered
  // One wait state keeps every answer output a flip-flop
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce_i) begin
      if (acc) begin
        rdy_q   <= 1'b1;
        err_q   <= ~mapped;
        rdata_q <= pwrite_i ? 32'h0000_0000 : rmux;
      end else begin
        rdy_q <= 1'b0;
        err_q <= 1'b0;
      end
    end
  end

  // Outputs straight from flip-flops
  assign prdata_o               = rdata_q;
  assign pready_o               = rdy_q;
  assign pslverr_o              = err_q;
  assign free_timer_irq_flag_o  = irq_free_q;
  assign multi_timer_irq_flag_o = irq_multi_q;

  // Checks share the one clock; reset disables them
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_ps_count_up: assert property (ps_en |=> ps_q == $past(ps_q) + 11'd1)
    else $error("Prescaler did not advance");
  a_ps_stop_hold: assert property (!ps_en |=> $stable(ps_q))
    else $error("Prescaler moved while stopped");
  a_ft_step_one: assert property (ce_i && ft_tick && ft_q != 8'hff
    |=> ft_q == $past(ft_q) + 8'd1)
    else $error("Free timer step wrong");
  a_ft_wrap_flag: assert property (ce_i && ft_tick && ft_q == 8'hff
    |=> ft_q == 8'h00 && irq_free_q)
    else $error("Free timer wrap wrong");
  a_mt_reload_val: assert property (ce_i && mt_ovf && !lh_wr && !trig
    |=> mt_q == ($past(m1_q.reload) ? {$past(lh_q), $past(ll_q)} : 8'h00))
    else $error("Overflow load wrong");
  a_mt_flag_hold: assert property (ce_i && mt_ovf
    |=> irq_multi_q ##1 (irq_multi_q || $past(wr)))
    else $error("Overflow flag lost");
  a_cap_copy_clear: assert property (ce_i && trig && !lh_wr
    |=> rd_q == $past(mt_q) && mt_q == 8'h00 && cap_q.stat)
    else $error("Capture wrong");
  a_cap_err_set: assert property (ce_i && cap_q.stat && (trig || mt_ovf)
    |=> cap_q.err)
    else $error("Capture error missed");
  a_mode_gap_keep: assert property (m1_wr_ok |=> !m1_wr_ok)
    else $error("Mode write too soon");
  a_high_load_val: assert property (lh_wr
    |=> mt_q == {$past(pwdata_i[3:0]), $past(ll_q)})
    else $error("High write load wrong");
  a_rd_low_snap: assert property (rd_hi && !m2_q.cap_en && !trig
    |=> rd_q[3:0] == $past(mt_q[3:0]))
    else $error("Low snapshot wrong");

  // While ce_i is low nothing may move, bus answer included
  a_ce_freeze_all: assert property (!ce_i
    |=> $stable(ps_q) && $stable(ft_q) && $stable(mt_q) && $stable(rdy_q))
    else $error("State moved while clock enable low");

  // Main scenarios the bench should reach
  c_ft_overflow: cover property (ce_i && ft_tick && ft_q == 8'hff);
  c_mt_reload:   cover property (ce_i && mt_ovf && m1_q.reload);
  c_cap_error:   cover property (ce_i && cap_q.stat && trig);
  c_ext_event:   cover property (ext_sel && edge_hit && ce_i);
  c_low_latch:   cover property (rd_hi && !m2_q.cap_en);

endmodule : ptmr_top
`default_nettype wire

// [ptmr_evt_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Outside source that drives the event and trigger pin
module ptmr_evt_model #(
  parameter int HOLD = 3  // Cycles each level stands; kept above the two-cycle floor
) (
  input  wire logic       clock_i,
  input  wire logic       go_i,
  input  wire logic [7:0] pairs_i,
  output logic            pin_o,
  output logic            busy_o
);
  // Idles high like a pulled-up line; each pair is a fall then a rise
  initial begin
    pin_o  = 1'b1;
    busy_o = 1'b0;
    forever begin
      @(posedge clock_i);
      if (go_i) begin
        busy_o <= 1'b1;
        repeat (pairs_i) begin
          pin_o <= 1'b0;
          repeat (HOLD) @(posedge clock_i);
          pin_o <= 1'b1;
          repeat (HOLD) @(posedge clock_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule : ptmr_evt_model
`default_nettype wire

// [testbench.sv]
`include "ptmr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ptmr_pkg::*;
  logic        clock_i;       // 50 MHz clock
  logic        rst_i;         // Async reset, high
  logic        ce_i;          // Enabled except for ten edges near the end
  logic        stop_i;        // Stop mode, freezes internal ticks
  logic        psel;          // APB select
  logic        penable;       // APB enable
  logic        pwrite;        // APB direction
  logic [11:0] paddr;         // APB byte address
  logic [31:0] pwdata;        // APB write data
  logic [31:0] prdata;        // APB read data
  logic        pready;        // APB answer
  logic        pslverr;       // APB error
  logic        fflag;         // Free timer flag
  logic        mflag;         // Multi timer flag
  logic        pin;           // Event pin from the source model
  logic        go;            // Start a burst of edge pairs
  logic [7:0]  pairs;         // Pairs in the burst
  logic        busy;          // Burst in progress
  logic        last_err;      // Error of the last transfer
  logic [31:0] last_rd;       // Read data of the last transfer
  int          num_errors;    // Mismatches
  int          total_checks;  // Comparisons
  int          cyc;           // Free cycle count
  int          t0;            // Stop release time
  int          t1;            // First free flag rise
  int          t2;            // Second free flag rise
  // Taps all zero: every code ticks each second cycle
  ptmr_top #(.TAPS(32'h0)) uut (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .stop_i(stop_i),
    .event_input_pin_i(pin), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .free_timer_irq_flag_o(fflag), .multi_timer_irq_flag_o(mflag));
  ptmr_evt_model evt_src (
    .clock_i(clock_i), .go_i(go), .pairs_i(pairs), .pin_o(pin), .busy_o(busy));
  // Clock source
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // Hang guard, well above the expected run length
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; pready sampled before the edge's own updates land
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [3:0] wd);
    int n;
    n = 0;
    @(posedge clock_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {28'h0, wd};
    @(posedge clock_i);
    penable <= 1'b1;
    // Hold the request until pready is seen high; the limit guards a hang
    do begin
      @(posedge clock_i);
      n = n + 1;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) num_errors++;
    last_rd  = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Read and compare the data taken at the answer edge
  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 4'h0);
    check(last_rd, exp);
  endtask : rd_chk
  // Count read, upper digit first so the lower one is a snapshot
  task automatic cnt_chk(input logic [7:0] exp);
    rd_chk(`PTMR_IDX_HIGH, {28'h0, exp[7:4]});
    rd_chk(`PTMR_IDX_LOW, {28'h0, exp[3:0]});
  endtask : cnt_chk
  // Load: lower digit first, upper digit moves it into the timer
  task automatic load(input logic [7:0] v);
    apb(1'b1, `PTMR_IDX_LOW, v[3:0]);
    apb(1'b1, `PTMR_IDX_HIGH, v[7:4]);
  endtask : load
  // Burst of edge pairs, then time for the pin edge detector
  task automatic events(input logic [7:0] n);
    int k;
    k = 0;
    @(posedge clock_i);
    pairs <= n;
    go    <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    repeat (2) @(posedge clock_i);
    while (busy === 1'b1 && k < 500) begin
      @(posedge clock_i);
      k = k + 1;
    end
    if (k >= 500) num_errors++;
    repeat (4) @(posedge clock_i);
  endtask : events
  // Wait for the free flag after at least one edge
  task automatic wait_flag();
    int k;
    k = 0;
    do begin
      @(posedge clock_i);
      k = k + 1;
    end while (fflag !== 1'b1 && k < 2000);
  endtask : wait_flag
  task automatic report_and_stop();
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence; stop mode keeps internal ticks still until the free timer part
  initial begin
    {num_errors, total_checks, cyc, t0, t1, t2} = '0;
    {psel, penable, pwrite, go, last_err} = '0;
    {paddr, pwdata, pairs} = '0;
    rst_i  = 1'b1;
    ce_i   = 1'b1;
    stop_i = 1'b1;
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    rd_chk(`PTMR_IDX_FREE_FLAG, 32'h0);
    rd_chk(`PTMR_IDX_CAP_FLAGS, 32'h0);
    rd_chk(`PTMR_IDX_MODE_ONE, 32'h0);
    apb(1'b0, 10'h3ff, 4'h0);
    check({31'h0, last_err}, 32'h1);
    // Upper-only write reuses the cleared lower digit
    apb(1'b1, `PTMR_IDX_HIGH, 4'h3);
    cnt_chk(8'h30);
    apb(1'b1, `PTMR_IDX_LOW, 4'h5);
    cnt_chk(8'h30);
    apb(1'b1, `PTMR_IDX_HIGH, 4'hf);
    cnt_chk(8'hf5);
    // Event counting on falling, rising and both edges
    apb(1'b1, `PTMR_IDX_PIN_FUNC, 4'h1);
    apb(1'b1, `PTMR_IDX_MODE_ONE, 4'h7);
    for (int m = 1; m <= 3; m++) begin
      apb(1'b1, `PTMR_IDX_MODE_TWO, 4'(m));
      load(8'h10);
      events(8'd3);
      cnt_chk((m == 3) ? 8'h16 : 8'h13);
    end
    // Lower digit snapshot taken by the upper read
    apb(1'b1, `PTMR_IDX_MODE_TWO, 4'h1);
    load(8'h1f);
    rd_chk(`PTMR_IDX_HIGH, 32'h1);
    events(8'd1);
    rd_chk(`PTMR_IDX_LOW, 32'hf);
    rd_chk(`PTMR_IDX_HIGH, 32'h2);
    // Free-running overflow past all-ones
    apb(1'b1, `PTMR_IDX_MODE_TWO, 4'h3);
    load(8'hfe);
    events(8'd2);
    cnt_chk(8'h02);
    check({31'h0, mflag}, 32'h1);
    apb(1'b1, `PTMR_IDX_MULTI_FLAG, 4'h0);
    rd_chk(`PTMR_IDX_MULTI_FLAG, 32'h0);
    // Reload mode returns to the written value
    apb(1'b1, `PTMR_IDX_MODE_ONE, 4'hf);
    load(8'hfe);
    events(8'd2);
    cnt_chk(8'hfe);
    apb(1'b1, `PTMR_IDX_MULTI_FLAG, 4'h0);
    // Capture on falling edge with an internal source
    apb(1'b1, `PTMR_IDX_MODE_ONE, 4'h0);
    apb(1'b1, `PTMR_IDX_MODE_TWO, 4'h5);
    load(8'h37);
    events(8'd1);
    rd_chk(`PTMR_IDX_CAP_FLAGS, 32'h1);
    rd_chk(`PTMR_IDX_MULTI_FLAG, 32'h1);
    rd_chk(`PTMR_IDX_LOW, 32'h7);
    rd_chk(`PTMR_IDX_HIGH, 32'h3);
    events(8'd1);
    rd_chk(`PTMR_IDX_CAP_FLAGS, 32'h3);
    cnt_chk(8'h00);
    apb(1'b1, `PTMR_IDX_CAP_FLAGS, 4'h0);
    rd_chk(`PTMR_IDX_CAP_FLAGS, 32'h0);
    // Free timer: nothing while stopped, then 256 ticks per flag
    check({31'h0, fflag}, 32'h0);
    apb(1'b1, `PTMR_IDX_FREE_MODE, 4'h0);
    @(posedge clock_i);
    stop_i <= 1'b0;
    t0 = cyc;
    wait_flag();
    t1 = cyc;
    check({31'h0, (t1 - t0 >= 500 && t1 - t0 <= 530)}, 32'h1);
    rd_chk(`PTMR_IDX_FREE_FLAG, 32'h4);
    apb(1'b1, `PTMR_IDX_FREE_FLAG, 4'h0);
    // Clock enable low for ten edges freezes everything, flag comes ten later
    ce_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    ce_i <= 1'b1;
    wait_flag();
    t2 = cyc;
    check(32'(t2 - t1), 32'd522);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
